// file: dpp_pkg.sv
// Constants of the channel progress and pattern match register set.
// Assumes a 32-bit register port with byte addresses on an 8-bit address.
package dpp_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 16;
	localparam int FULL_W = 17;
	localparam int INT_W = 3;

	// Register byte offsets
	localparam logic [7:0] OFF_SOURCE_POSITION = 8'h00;
	localparam logic [7:0] OFF_DESTINATION_POSITION = 8'h04;
	localparam logic [7:0] OFF_CELL_LENGTH = 8'h08;
	localparam logic [7:0] OFF_CELL_PROGRESS = 8'h0C;
	localparam logic [7:0] OFF_MATCH_VALUE = 8'h10;
	localparam logic [7:0] OFF_CONTROL = 8'h14;
	localparam logic [7:0] OFF_SOURCE_SIZE = 8'h18;
	localparam logic [7:0] OFF_DESTINATION_SIZE = 8'h1C;
	localparam logic [7:0] OFF_INT_STATUS = 8'h20;
	localparam logic [7:0] OFF_INT_CLEAR = 8'h24;
	localparam logic [7:0] OFF_INT_ENABLE = 8'h28;

	// Control fields
	localparam int CTRL_PATTERN_MODE = 0;
	localparam int CTRL_MATCH_WIDE = 1;
	localparam int CTRL_W = 2;

	// Interrupt status fields
	localparam int INT_CELL_DONE = 0;
	localparam int INT_BLOCK_DONE = 1;
	localparam int INT_DEST_HALF = 2;

	// Reset values
	localparam logic [15:0] RST_FIELD = 16'h0000;
	localparam logic [1:0] RST_CTRL = 2'h0;
	localparam logic [2:0] RST_INT = 3'h0;
	localparam logic [31:0] RST_READ = 32'h0000_0000;

	// Low byte mask for narrow pattern compare
	localparam logic [15:0] BYTE_MASK = 16'h00FF;

	// Cell sequencing states
	typedef enum logic [0:0] {
		DPP_IDLE = 1'b0,
		DPP_CELL = 1'b1
	} dpp_state_e;

endpackage

// file: dpp_counter.sv
// Byte position counter with clear priority over step.
// Assumes clear and step come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dpp_counter #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Control
	input wire logic clear,
	input wire logic step,
	// Value
	output logic [W-1:0] count
);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else if (step) begin
			count <= count + {{(W-1){1'b0}}, 1'b1};
		end
	end

endmodule
`default_nettype wire

// file: dpp_channel.sv
// Channel progress tracking and pattern match register set.
// Assumes the transfer engine on core_clk reports each moved byte and data.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module dpp_channel (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdData,
	// Transfer engine
	input wire logic cellTrigger,
	input wire logic srcByteMoved,
	input wire logic dstByteMoved,
	input wire logic [15:0] xferData,
	input wire logic xferDataValid,
	output logic cellActive,
	output logic transferEnd,
	// Interrupt
	output logic irq
);

	logic [15:0] cellByteLength;
	logic [15:0] matchPatternValue;
	logic [1:0] control;
	logic [15:0] sourceSize;
	logic [15:0] destinationSize;
	logic [2:0] intStatus;
	logic [2:0] intEnable;
	logic [15:0] sourceByteIndex;
	logic [15:0] destinationByteIndex;
	logic [15:0] cellProgressCount;
	logic [16:0] blockCount;
	dpp_pkg::dpp_state_e state;
	dpp_pkg::dpp_state_e next_state;

	logic patternMode;
	logic patternEvt;
	logic cellStart;
	logic cellStep;
	logic cellEvt;
	logic blockEvt;
	logic halfEvt;
	logic [16:0] cellFull;
	logic [16:0] srcFull;
	logic [16:0] dstFull;
	logic [16:0] blockFull;
	logic [16:0] cellNext;
	logic [16:0] dstHalf;
	logic [15:0] patternMask;
	logic [2:0] intSet;
	logic [2:0] intClr;
	logic [31:0] next_rdData;

	// Zero stands for the full 65,536 byte count
	assign cellFull = {cellByteLength == dpp_pkg::RST_FIELD, cellByteLength};
	assign srcFull = {sourceSize == dpp_pkg::RST_FIELD, sourceSize};
	assign dstFull = {destinationSize == dpp_pkg::RST_FIELD, destinationSize};
	assign blockFull = (srcFull > dstFull) ? srcFull : dstFull;
	assign dstHalf = {1'b0, dstFull[16:1]};

	assign patternMode = control[dpp_pkg::CTRL_PATTERN_MODE];
	assign patternMask = control[dpp_pkg::CTRL_MATCH_WIDE] ? 16'hFFFF :
		dpp_pkg::BYTE_MASK;
	// Compare only in pattern mode, the value is dormant otherwise
	assign patternEvt = patternMode && xferDataValid &&
		((xferData & patternMask) == (matchPatternValue & patternMask));

	assign cellStart = cellTrigger && (state == dpp_pkg::DPP_IDLE);
	assign cellStep = dstByteMoved && (state == dpp_pkg::DPP_CELL);
	assign cellNext = {1'b0, cellProgressCount} + 17'h00001;
	assign cellEvt = cellStep && (cellNext == cellFull);
	assign blockEvt = dstByteMoved &&
		((blockCount + 17'h00001) == blockFull);
	assign halfEvt = dstByteMoved &&
		(({1'b0, destinationByteIndex} + 17'h00001) == dstHalf);

	// Source position: cleared by a detect or at block end
	dpp_counter #(.W(dpp_pkg::CNT_W)) uSrc (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clear(patternEvt || blockEvt),
		.step(srcByteMoved),
		.count(sourceByteIndex)
	);

	dpp_counter #(.W(dpp_pkg::CNT_W)) uDst (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clear(blockEvt),
		.step(dstByteMoved),
		.count(destinationByteIndex)
	);

	dpp_counter #(.W(dpp_pkg::CNT_W)) uCell (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clear(cellStart || patternEvt),
		.step(cellStep),
		.count(cellProgressCount)
	);

	// Block count spans 65,536 so it needs the extra bit
	dpp_counter #(.W(dpp_pkg::FULL_W)) uBlock (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clear(blockEvt || patternEvt),
		.step(dstByteMoved),
		.count(blockCount)
	);

	// Cell sequencing; a trigger during a cell is dropped
	always_comb begin
		next_state = state;
		case (state)
			dpp_pkg::DPP_IDLE: begin
				if (cellTrigger) begin
					next_state = dpp_pkg::DPP_CELL;
				end
			end
			dpp_pkg::DPP_CELL: begin
				if (cellEvt || blockEvt || patternEvt) begin
					next_state = dpp_pkg::DPP_IDLE;
				end
			end
			default: begin
				next_state = dpp_pkg::DPP_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= dpp_pkg::DPP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cellActive <= 1'b0;
			transferEnd <= 1'b0;
		end else begin
			cellActive <= (next_state == dpp_pkg::DPP_CELL);
			transferEnd <= blockEvt || patternEvt;
		end
	end

	// Writable fields keep only low bits: 16 for values and sizes, 2 for control, 3 for enable
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cellByteLength <= dpp_pkg::RST_FIELD;
			matchPatternValue <= dpp_pkg::RST_FIELD;
			control <= dpp_pkg::RST_CTRL;
			sourceSize <= dpp_pkg::RST_FIELD;
			destinationSize <= dpp_pkg::RST_FIELD;
			intEnable <= dpp_pkg::RST_INT;
		end else if (regWrite) begin
			case (regAddr)
				dpp_pkg::OFF_CELL_LENGTH: cellByteLength <= regWrData[15:0];
				dpp_pkg::OFF_MATCH_VALUE: matchPatternValue <= regWrData[15:0];
				dpp_pkg::OFF_CONTROL: control <= regWrData[1:0];
				dpp_pkg::OFF_SOURCE_SIZE: sourceSize <= regWrData[15:0];
				dpp_pkg::OFF_DESTINATION_SIZE: destinationSize <= regWrData[15:0];
				dpp_pkg::OFF_INT_ENABLE: intEnable <= regWrData[2:0];
				default: begin
				end
			endcase
		end
	end

	// Sticky flags; a new event beats a clear in the same cycle
	assign intSet = {halfEvt, blockEvt || patternEvt, cellEvt};
	assign intClr = (regWrite && regAddr == dpp_pkg::OFF_INT_CLEAR) ?
		regWrData[2:0] : dpp_pkg::RST_INT;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			intStatus <= dpp_pkg::RST_INT;
		end else begin
			intStatus <= (intStatus & ~intClr) | intSet;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_intStatus() & intEnable);
		end
	end

	function automatic logic [2:0] next_intStatus();
		return (intStatus & ~intClr) | intSet;
	endfunction

	// Upper half is always zero; unmapped addresses read zero
	always_comb begin
		next_rdData = dpp_pkg::RST_READ;
		case (regAddr)
			dpp_pkg::OFF_SOURCE_POSITION: next_rdData[15:0] = sourceByteIndex;
			dpp_pkg::OFF_DESTINATION_POSITION:
				next_rdData[15:0] = destinationByteIndex;
			dpp_pkg::OFF_CELL_LENGTH: next_rdData[15:0] = cellByteLength;
			dpp_pkg::OFF_CELL_PROGRESS: next_rdData[15:0] = cellProgressCount;
			dpp_pkg::OFF_MATCH_VALUE: next_rdData[15:0] = matchPatternValue;
			dpp_pkg::OFF_CONTROL: next_rdData[1:0] = control;
			dpp_pkg::OFF_SOURCE_SIZE: next_rdData[15:0] = sourceSize;
			dpp_pkg::OFF_DESTINATION_SIZE: next_rdData[15:0] = destinationSize;
			dpp_pkg::OFF_INT_STATUS: next_rdData[2:0] = intStatus;
			dpp_pkg::OFF_INT_ENABLE: next_rdData[2:0] = intEnable;
			default: next_rdData = dpp_pkg::RST_READ;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			regRdData <= dpp_pkg::RST_READ;
		end else if (regRead) begin
			regRdData <= next_rdData;
		end else begin
			regRdData <= dpp_pkg::RST_READ;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	a_src_pos_count:
	assert property (srcByteMoved && !patternEvt && !blockEvt |=>
		sourceByteIndex == 16'($past(sourceByteIndex) + 16'h0001))
		else $error("source position did not advance");

	a_src_pattern_clear:
	assert property (patternEvt |=> sourceByteIndex == 16'h0000)
		else $error("source position not cleared on pattern detect");

	a_dst_pos_count:
	assert property (dstByteMoved && !blockEvt |=>
		destinationByteIndex == 16'($past(destinationByteIndex) + 16'h0001))
		else $error("destination position did not advance");

	a_cell_length_end:
	assert property (cellEvt && !patternEvt |=> !cellActive &&
		cellProgressCount == 16'($past(cellFull))
		##1 (!cellActive || $past(cellStart)))
		else $error("cell did not end at cell length");

	a_cell_prog_step:
	assert property (cellStep && !patternEvt |=>
		cellProgressCount == 16'($past(cellProgressCount) + 16'h0001))
		else $error("cell progress did not advance");

	a_cell_pattern_clear:
	assert property (patternEvt |=> cellProgressCount == 16'h0000)
		else $error("cell progress not cleared on pattern detect");

	a_match_mode_only:
	assert property (!patternMode && !blockEvt |=> !transferEnd)
		else $error("pattern compare outside pattern mode");

	a_upper_half_zero:
	assert property (regRead |=> regRdData[31:16] == 16'h0000)
		else $error("upper half of read data not zero");

	a_cell_done_flag:
	assert property (cellEvt |=> intStatus[dpp_pkg::INT_CELL_DONE])
		else $error("cell done flag not raised");

	a_dest_half_flag:
	assert property (halfEvt && !blockEvt |=> intStatus[dpp_pkg::INT_DEST_HALF]
		&& destinationByteIndex == 16'($past(dstHalf)))
		else $error("destination half flag wrong");

	a_block_done_end:
	assert property (blockEvt || patternEvt |=>
		intStatus[dpp_pkg::INT_BLOCK_DONE] && transferEnd
		##1 (!transferEnd || $past(blockEvt || patternEvt)))
		else $error("block done not flagged");

	a_cell_restart_zero:
	assert property (cellStart && !cellStep |=> cellProgressCount == 16'h0000
		&& cellActive)
		else $error("cell progress not cleared at trigger");

	c_cell_done: cover property (cellEvt ##[1:20] cellStart);
	c_pattern_hit: cover property (cellActive ##1 patternEvt);
	c_block_done: cover property (blockEvt && intEnable != 3'h0 ##1 irq);

endmodule
`default_nettype wire

// file: dpp_engine_model.sv
// Transfer engine model: cell trigger and byte pulses toward the channel.
// Assumes one bench thread calls its tasks, on core_clk edges only.
`timescale 1ns/1ps
`default_nettype none
module dpp_engine_model (
	// Clock
	input wire logic core_clk,
	// Engine strobes
	output logic cellTrigger,
	output logic srcByteMoved,
	output logic dstByteMoved,
	output logic [15:0] xferData,
	output logic xferDataValid
);
	initial begin
		cellTrigger = 1'b0;
		srcByteMoved = 1'b0;
		dstByteMoved = 1'b0;
		xferDataValid = 1'b0;
		xferData = 16'hA5A5;
	end

	task automatic trigger();
		@(posedge core_clk);
		cellTrigger <= 1'b1;
		@(posedge core_clk);
		cellTrigger <= 1'b0;
	endtask

	// Released data is inverted so a stale value never matches by chance
	task automatic idle();
		@(posedge core_clk);
		srcByteMoved <= 1'b0;
		dstByteMoved <= 1'b0;
		xferDataValid <= 1'b0;
		xferData <= ~xferData;
	endtask

	// Gap zero keeps the strobes up for a back-to-back byte
	task automatic move(input logic [15:0] d, input int gap);
		@(posedge core_clk);
		srcByteMoved <= 1'b1;
		dstByteMoved <= 1'b1;
		xferDataValid <= 1'b1;
		xferData <= d;
		if (gap > 0) begin
			idle();
			repeat (gap - 1) @(posedge core_clk);
		end
	endtask
endmodule
`default_nettype wire

// file: dpp_channel_test.sv
// Self-checking bench for the channel progress and pattern register set.
// Assumes the engine model drives the transfer side, the bench the registers.
`timescale 1ns/1ps
`default_nettype none
module dpp_channel_test;
	logic core_clk, reset_n, regWrite, regRead;
	logic [7:0] regAddr;
	logic [31:0] regWrData, regRdData, seed;
	logic cellTrigger, srcByteMoved, dstByteMoved, xferDataValid;
	logic cellActive, transferEnd, irq;
	logic [15:0] xferData, pat;
	int n_mismatch, comparisons, cycles, ends, len;

	dpp_channel dut_u (.core_clk(core_clk), .reset_n(reset_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .cellTrigger(cellTrigger),
		.srcByteMoved(srcByteMoved), .dstByteMoved(dstByteMoved),
		.xferData(xferData), .xferDataValid(xferDataValid),
		.cellActive(cellActive), .transferEnd(transferEnd), .irq(irq));
	dpp_engine_model eng_u (.core_clk(core_clk), .cellTrigger(cellTrigger),
		.srcByteMoved(srcByteMoved), .dstByteMoved(dstByteMoved),
		.xferData(xferData), .xferDataValid(xferDataValid));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		@(posedge core_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1;
		check(what, regRdData, exp);
	endtask

	// Sticky status expected after a given count of moved bytes
	function automatic logic [31:0] flags(input int moved, input int size);
		flags = 32'h0000_0001;
		if (moved >= size / 2)
			flags[dpp_pkg::INT_DEST_HALF] = 1'b1;
		if (moved >= size)
			flags[dpp_pkg::INT_BLOCK_DONE] = 1'b1;
	endfunction

	task automatic run_cell(input logic [15:0] d);
		eng_u.trigger();
		rd("progress at trigger", dpp_pkg::OFF_CELL_PROGRESS, 32'h0);
		for (int i = 0; i < len; i++)
			eng_u.move(d, i % 2);
		eng_u.idle();
		repeat (3) @(posedge core_clk);
		#1;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (transferEnd === 1'b1)
			ends++;
		if (cycles == 5000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial begin
		seed = 32'h6D1E;
		reset_n = 1'b0;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWrData = 32'h0000_0000;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		pat = 16'($random(seed));
		len = 1 + ($random(seed) & 3);
		for (int a = 0; a <= 8'h30; a += 4)
			rd("reset value", 8'(a), 32'h0);
		$display("test reset done");
		wr(dpp_pkg::OFF_CELL_LENGTH, 32'hFFFF_0000 | len);
		rd("cell length", dpp_pkg::OFF_CELL_LENGTH, 32'(len));
		// Nonzero data must drop back to zero one cycle later
		@(posedge core_clk);
		#1;
		check("data after read", regRdData, 32'h0);
		wr(dpp_pkg::OFF_MATCH_VALUE, {16'hFFFF, pat});
		rd("match value", dpp_pkg::OFF_MATCH_VALUE, {16'h0, pat});
		wr(dpp_pkg::OFF_SOURCE_POSITION, 32'hFFFF_FFFF);
		rd("source read only", dpp_pkg::OFF_SOURCE_POSITION, 32'h0);
		wr(8'h30, 32'hFFFF_FFFF);
		rd("unmapped", 8'h30, 32'h0);
		$display("test registers done");
		wr(dpp_pkg::OFF_SOURCE_SIZE, 32'(2 * len));
		wr(dpp_pkg::OFF_DESTINATION_SIZE, 32'(2 * len));
		run_cell(pat);
		check("cell active", 32'(cellActive), 32'h0);
		rd("progress", dpp_pkg::OFF_CELL_PROGRESS, 32'(len));
		rd("source", dpp_pkg::OFF_SOURCE_POSITION, 32'(len));
		rd("dest", dpp_pkg::OFF_DESTINATION_POSITION, 32'(len));
		rd("status", dpp_pkg::OFF_INT_STATUS, flags(len, 2 * len));
		check("irq masked", 32'(irq), 32'h0);
		wr(dpp_pkg::OFF_INT_ENABLE, 32'h0000_0001);
		repeat (2) @(posedge core_clk);
		#1;
		check("irq raised", 32'(irq), 32'h1);
		wr(dpp_pkg::OFF_INT_CLEAR, 32'h0000_0001);
		repeat (2) @(posedge core_clk);
		#1;
		check("irq cleared", 32'(irq), 32'h0);
		run_cell(~pat);
		check("irq again", 32'(irq), 32'h1);
		rd("status block", dpp_pkg::OFF_INT_STATUS, flags(2 * len, 2 * len));
		rd("source wrap", dpp_pkg::OFF_SOURCE_POSITION, 32'h0);
		rd("dest wrap", dpp_pkg::OFF_DESTINATION_POSITION, 32'h0);
		check("block end pulse", 32'(ends), 32'h1);
		$display("test cells done");
		wr(dpp_pkg::OFF_INT_CLEAR, 32'h0000_0007);
		wr(dpp_pkg::OFF_CONTROL, 32'h0000_0001);
		wr(dpp_pkg::OFF_CELL_LENGTH, 32'h0);
		// Full sizes keep half and block events away from the match
		wr(dpp_pkg::OFF_SOURCE_SIZE, 32'h0);
		wr(dpp_pkg::OFF_DESTINATION_SIZE, 32'h0);
		eng_u.trigger();
		eng_u.move(pat ^ 16'h0055, 0);
		eng_u.move(pat ^ 16'h0055, 1);
		eng_u.move({~pat[15:8], pat[7:0]}, 1);
		repeat (2) @(posedge core_clk);
		#1;
		check("pattern stop", 32'(cellActive), 32'h0);
		rd("source cleared", dpp_pkg::OFF_SOURCE_POSITION, 32'h0);
		rd("progress cleared", dpp_pkg::OFF_CELL_PROGRESS, 32'h0);
		rd("match status", dpp_pkg::OFF_INT_STATUS, 32'h0000_0002);
		check("match end pulse", 32'(ends), 32'h2);
		$display("test pattern done");
		// Low byte alone must not match once the wide compare is on
		wr(dpp_pkg::OFF_CONTROL, 32'h0000_0003);
		eng_u.trigger();
		eng_u.move({~pat[15:8], pat[7:0]}, 1);
		eng_u.move(pat, 1);
		repeat (2) @(posedge core_clk);
		#1;
		check("wide match end", 32'(ends), 32'h3);
		rd("wide source", dpp_pkg::OFF_SOURCE_POSITION, 32'h0);
		$display("test wide match done");
		give_verdict();
	end
endmodule
`default_nettype wire
